/* File: include/liu_diag_defs.svh */
// register addresses, field positions, reset values and thresholds of the diagnostics block
`ifndef LIU_DIAG_DEFS_SVH
`define LIU_DIAG_DEFS_SVH

// register addresses
`define ADDR_CTRL 8'h04
`define ADDR_STATUS 8'h05
`define ADDR_ERR_LOW 8'h30
`define ADDR_ERR_HIGH 8'h31
`define ADDR_ERR_HOLD 8'h38
`define ADDR_DEV_ID 8'h3e
`define ADDR_SIL_VER 8'h3f

// control register fields
`define CTRL_ALL_ONES 0
`define CTRL_LOCAL_LOOP 1
`define CTRL_REMOTE_LOOP 2
`define CTRL_ERR_INSERT 3
`define CTRL_E3_RATE 4
`define CTRL_PATTERN_EN 5
`define CTRL_RESET 8'h00
`define CTRL_WMASK 8'h3f

// status register field
`define STAT_LOCK_LOSS 0

// fields of the configuration word that crosses into the link domain
`define CFG_PATTERN 4
`define CFG_E3 3
`define CFG_ALL_ONES 2
`define CFG_MODE_HI 1
`define CFG_RESET 5'h00

// error counter
`define ERR_CNT_MAX 16'hffff
`define ERR_CNT_ZERO 16'h0000
`define ERR_CNT_ONE 16'h0001

// pattern polynomial taps: x^15+x^14+1 and x^23+x^18+1
`define LFSR_SEED 23'h7fffff
`define TAP15_A 14
`define TAP15_B 13
`define TAP23_A 22
`define TAP23_B 17

// checker thresholds
`define SYNC_GOOD_RUN 6'd32
`define LOSS_ERR_COUNT 3'd4

// identification values, arbitrary
`define DEV_ID_VALUE 8'h5a
`define SIL_VER_VALUE 8'h03

`endif

/* File: include/liu_diag_pkg.sv */
// shared types of the diagnostics block
package liu_diag_pkg;
    // loopback selection after priority resolution
    typedef enum logic [1:0] {loop_none, loop_analog, loop_digital, loop_remote} loop_mode_type;
    // checker synchronisation state
    typedef enum logic {chk_hunt, chk_locked} check_state_type;
endpackage

/* File: design/prbs_gen.sv */
// pseudo-random pattern generator with single-bit corruption
`timescale 1ns/100ps
`default_nettype none
`include "liu_diag_defs.svh"
module prbs_gen (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic i_e3_rate,
    input wire logic i_flip,
    output logic o_bit
);
    typedef struct packed {
        logic [22:0] lfsr; // shift register
        logic bit_out;     // transmitted bit
    } gen_state_type;

    gen_state_type q, d;
    logic fb; // feedback of the selected polynomial

    // next state: shift while running, park at the seed otherwise
    always_comb begin
        d = q;
        fb = i_e3_rate ? (q.lfsr[`TAP23_A] ^ q.lfsr[`TAP23_B]) : (q.lfsr[`TAP15_A] ^ q.lfsr[`TAP15_B]);
        if (i_run) begin
            d.lfsr = {q.lfsr[21:0], fb};
            d.bit_out = fb ^ i_flip; // corrupt one bit, lfsr stays clean
        end else begin
            d.lfsr = `LFSR_SEED;
            d.bit_out = 1'b0;
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q <= '{lfsr: `LFSR_SEED, bit_out: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign o_bit = q.bit_out;
endmodule // prbs_gen
`default_nettype wire

/* File: design/prbs_check.sv */
// self-synchronising pattern checker
`timescale 1ns/100ps
`default_nettype none
`include "liu_diag_defs.svh"
module prbs_check (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic i_e3_rate,
    input wire logic i_bit,
    output logic o_error,
    output logic o_in_sync
);
    typedef struct packed {
        liu_diag_pkg::check_state_type st; // hunt or locked
        logic [22:0] shift;                // last received bits
        logic [5:0] good_run;              // consecutive matching bits
        logic [2:0] burst;                 // errors since last long clean run
        logic error;                       // one-cycle error flag
    } chk_state_type;

    chk_state_type q, d;
    logic pred; // bit the sequence predicts
    logic mism; // received bit disagrees

    // next state: compare against prediction, track lock
    always_comb begin
        d = q;
        pred = i_e3_rate ? (q.shift[`TAP23_A] ^ q.shift[`TAP23_B]) : (q.shift[`TAP15_A] ^ q.shift[`TAP15_B]);
        mism = pred ^ i_bit;
        d.shift = {q.shift[21:0], i_bit};
        d.error = i_run & mism; // errors counted during acquisition too
        d.good_run = mism ? 6'd0 : q.good_run + 6'd1;
        if (!i_run) begin
            d.st = liu_diag_pkg::chk_hunt;
            d.good_run = 6'd0;
            d.burst = 3'd0;
            d.error = 1'b0;
        end else begin
            unique case (q.st)
                liu_diag_pkg::chk_hunt: begin
                    d.burst = 3'd0;
                    // a clean run long enough to rule out chance matches
                    if (!mism && q.good_run == `SYNC_GOOD_RUN - 6'd1) begin
                        d.st = liu_diag_pkg::chk_locked;
                    end
                end
                liu_diag_pkg::chk_locked: begin
                    if (mism) begin
                        d.burst = q.burst + 3'd1;
                        // one inserted error gives three mismatches, so loss needs four
                        if (q.burst == `LOSS_ERR_COUNT - 3'd1) begin
                            d.st = liu_diag_pkg::chk_hunt;
                        end
                    end else if (q.good_run == `SYNC_GOOD_RUN - 6'd1) begin
                        d.burst = 3'd0;
                    end
                    if (d.good_run == `SYNC_GOOD_RUN) begin
                        d.good_run = 6'd0;
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q <= '{st: liu_diag_pkg::chk_hunt, shift: 23'h0, good_run: 6'd0, burst: 3'd0, error: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign o_error = q.error;
    assign o_in_sync = (q.st == liu_diag_pkg::chk_locked);
endmodule // prbs_check
`default_nettype wire

/* File: design/liu_diag_top.sv */
// line interface diagnostics: pattern test, error counter, loopbacks, all-ones, identification
`timescale 1ns/100ps
`default_nettype none
`include "liu_diag_defs.svh"
module liu_diag_top #(
    parameter logic [7:0] DEVICE_ID = `DEV_ID_VALUE,  // arbitrary value
    parameter logic [7:0] SILICON_VER = `SIL_VER_VALUE // arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_link_clk,
    input wire logic i_host_mode,
    input wire logic i_remote_loop_select,
    input wire logic i_local_loop_select,
    input wire logic i_transmit_all_ones,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    input wire logic i_tx_positive_data_in,
    input wire logic i_tx_negative_data_in,
    output logic o_line_tx_positive,
    output logic o_line_tx_negative,
    input wire logic i_line_rx_positive,
    input wire logic i_line_rx_negative,
    output logic o_recovered_clock_out,
    output logic o_rx_positive_data_out,
    output logic o_rx_negative_or_violation_out
);
    // ---------------- register domain ----------------
    typedef struct packed {
        logic [3:0] pin_meta;  // pin synchroniser, first stage
        logic [3:0] pin_sync;  // host, remote, local, all-ones
        logic [7:0] ctrl;      // control register
        logic [4:0] cfg;       // resolved configuration to the link
        logic ins_toggle;      // one flip per error insertion
        logic loss_meta;       // lock loss, first stage
        logic loss_sync;       // lock loss, synchronised
        logic err_meta;        // error toggle, first stage
        logic err_sync;        // error toggle, synchronised
        logic err_seen;        // last toggle value consumed
        logic [15:0] err_cnt;  // error counter
        logic [7:0] hold;      // holding register
        logic [7:0] rdata;     // read data
    } sys_state_type;

    // ---------------- link domain ----------------
    typedef struct packed {
        logic [4:0] cfg_meta;  // configuration, first stage
        logic [4:0] cfg_sync;  // configuration, synchronised
        logic [4:0] cfg_prev;  // previous synchronised sample
        logic [4:0] cfg_used;  // configuration once two samples agree
        logic ins_meta;        // insertion toggle, first stage
        logic ins_sync;        // insertion toggle, synchronised
        logic ins_seen;        // last toggle value consumed
        logic tx_p;            // line positive output
        logic tx_n;            // line negative output
        logic ami_phase;       // polarity of the next mark
        logic rx_p;            // receive positive output
        logic rx_n;            // receive negative output
        logic loss;            // lock loss level to the register side
        logic err_toggle;      // flips on every detected error
    } link_state_type;

    sys_state_type s_q, s_d;
    link_state_type l_q, l_d;
    logic rst_meta; // link reset, first stage
    logic link_rst; // reset in the link domain
    logic err_neg;  // error toggle copied on the falling edge
    logic gen_bit;  // pattern bit to send
    logic chk_err;  // checker saw an error
    logic chk_sync; // checker locked
    logic flip;     // corrupt the next pattern bit
    logic pat;      // pattern mode, link view
    logic all_ones; // all-ones, link view
    logic e3;       // E3 rate, link view
    logic line_in_p; // line receive after analog loop select
    logic line_in_n;
    logic rx_in_p;  // receive path after digital loop select
    logic rx_in_n;
    liu_diag_pkg::loop_mode_type mode; // active loopback, link view
    liu_diag_pkg::loop_mode_type sys_mode; // active loopback, register view
    logic host;     // register-configured mode
    logic rl;       // remote loop request
    logic ll;       // local loop request
    logic err_evt;  // one error event arrived this cycle
    logic cnt_inc;  // counter increments
    logic cnt_clr;  // counter read-clear
    logic rd_low;   // read of the low counter byte
    logic rd_high;  // read of the high counter byte
    logic ctrl_wr;  // write of the control register

    // register side next state
    always_comb begin
        s_d = s_q;
        s_d.pin_meta = {i_host_mode, i_remote_loop_select, i_local_loop_select, i_transmit_all_ones};
        s_d.pin_sync = s_q.pin_meta;
        host = s_q.pin_sync[3];
        // pins steer loops in pin mode, control bits in register mode
        rl = host ? s_q.ctrl[`CTRL_REMOTE_LOOP] : s_q.pin_sync[2];
        ll = host ? s_q.ctrl[`CTRL_LOCAL_LOOP] : s_q.pin_sync[1];
        // both selected resolves to digital, so only one loop is ever active
        if (rl && ll) begin
            sys_mode = liu_diag_pkg::loop_digital;
        end else if (rl) begin
            sys_mode = liu_diag_pkg::loop_remote;
        end else if (ll) begin
            sys_mode = liu_diag_pkg::loop_analog;
        end else begin
            sys_mode = liu_diag_pkg::loop_none;
        end
        s_d.cfg[`CFG_PATTERN] = host & s_q.ctrl[`CTRL_PATTERN_EN];
        s_d.cfg[`CFG_E3] = s_q.ctrl[`CTRL_E3_RATE];
        s_d.cfg[`CFG_ALL_ONES] = host ? s_q.ctrl[`CTRL_ALL_ONES] : s_q.pin_sync[0];
        s_d.cfg[`CFG_MODE_HI:0] = sys_mode;
        // crossings from the link
        s_d.loss_meta = l_q.loss;
        s_d.loss_sync = s_q.loss_meta;
        s_d.err_meta = l_q.err_toggle;
        s_d.err_sync = s_q.err_meta;
        s_d.err_seen = s_q.err_sync;
        err_evt = s_q.err_sync ^ s_q.err_seen;
        // control write; an insertion needs a fresh 0 to 1 change of the bit
        ctrl_wr = i_reg_wr && i_reg_addr == `ADDR_CTRL;
        if (ctrl_wr) begin
            s_d.ctrl = i_reg_wdata & `CTRL_WMASK;
            if (host && i_reg_wdata[`CTRL_PATTERN_EN] && i_reg_wdata[`CTRL_ERR_INSERT]
                    && !s_q.ctrl[`CTRL_ERR_INSERT]) begin
                s_d.ins_toggle = ~s_q.ins_toggle;
            end
        end
        // counter: a read clears it, an error in the same cycle still counts
        rd_low = i_reg_rd && i_reg_addr == `ADDR_ERR_LOW;
        rd_high = i_reg_rd && i_reg_addr == `ADDR_ERR_HIGH;
        cnt_clr = rd_low || rd_high;
        cnt_inc = err_evt && s_q.cfg[`CFG_PATTERN] && (cnt_clr || s_q.err_cnt != `ERR_CNT_MAX);
        if (cnt_clr) begin
            s_d.err_cnt = cnt_inc ? `ERR_CNT_ONE : `ERR_CNT_ZERO;
            s_d.hold = rd_low ? s_q.err_cnt[15:8] : s_q.err_cnt[7:0];
        end else if (cnt_inc) begin
            s_d.err_cnt = s_q.err_cnt + `ERR_CNT_ONE;
        end
        // read data, registered; unmapped addresses read zero
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                `ADDR_CTRL: s_d.rdata = s_q.ctrl;
                `ADDR_STATUS: s_d.rdata = {7'h00, s_q.loss_sync};
                `ADDR_ERR_LOW: s_d.rdata = s_q.err_cnt[7:0];
                `ADDR_ERR_HIGH: s_d.rdata = s_q.err_cnt[15:8];
                `ADDR_ERR_HOLD: s_d.rdata = s_q.hold;
                `ADDR_DEV_ID: s_d.rdata = DEVICE_ID;
                `ADDR_SIL_VER: s_d.rdata = SILICON_VER;
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    // register side state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q <= '{pin_meta: 4'h0, pin_sync: 4'h0, ctrl: `CTRL_RESET, cfg: `CFG_RESET, ins_toggle: 1'b0,
                     loss_meta: 1'b0, loss_sync: 1'b0, err_meta: 1'b0, err_sync: 1'b0, err_seen: 1'b0,
                     err_cnt: `ERR_CNT_ZERO, hold: 8'h00, rdata: 8'h00};
        end else begin
            s_q <= s_d;
        end
    end

    // reset carried into the link clock
    always_ff @(posedge i_link_clk) begin
        rst_meta <= i_rst;
        link_rst <= rst_meta;
    end

    prbs_gen u_gen (
        .i_clk(i_link_clk),
        .i_rst(link_rst),
        .i_run(pat),
        .i_e3_rate(e3),
        .i_flip(flip),
        .o_bit(gen_bit)
    );

    prbs_check u_chk (
        .i_clk(i_link_clk),
        .i_rst(link_rst),
        .i_run(pat),
        .i_e3_rate(e3),
        .i_bit(rx_in_p | rx_in_n),
        .o_error(chk_err),
        .o_in_sync(chk_sync)
    );

    // link side next state
    always_comb begin
        l_d = l_q;
        l_d.cfg_meta = s_q.cfg;
        l_d.cfg_sync = l_q.cfg_meta;
        l_d.cfg_prev = l_q.cfg_sync;
        // bits of one word may land a link edge apart; take it only once two samples agree
        if (l_q.cfg_sync == l_q.cfg_prev) begin
            l_d.cfg_used = l_q.cfg_sync;
        end
        pat = l_q.cfg_used[`CFG_PATTERN];
        e3 = l_q.cfg_used[`CFG_E3];
        all_ones = l_q.cfg_used[`CFG_ALL_ONES];
        mode = liu_diag_pkg::loop_mode_type'(l_q.cfg_used[`CFG_MODE_HI:0]);
        l_d.ins_meta = s_q.ins_toggle;
        l_d.ins_sync = l_q.ins_meta;
        l_d.ins_seen = l_q.ins_sync;
        flip = pat & (l_q.ins_sync ^ l_q.ins_seen);
        // analog loop takes our own line output and drops the line input
        line_in_p = (mode == liu_diag_pkg::loop_analog) ? l_q.tx_p : i_line_rx_positive;
        line_in_n = (mode == liu_diag_pkg::loop_analog) ? l_q.tx_n : i_line_rx_negative;
        // digital loop replaces the receive path by the transmit inputs
        rx_in_p = (mode == liu_diag_pkg::loop_digital) ? i_tx_positive_data_in : line_in_p;
        rx_in_n = (mode == liu_diag_pkg::loop_digital) ? i_tx_negative_data_in : line_in_n;
        l_d.rx_p = rx_in_p;
        l_d.rx_n = rx_in_n;
        // transmit source in priority order
        if (mode == liu_diag_pkg::loop_digital) begin
            l_d.tx_p = 1'b0;
            l_d.tx_n = 1'b0;
        end else if (mode == liu_diag_pkg::loop_remote) begin
            // the register stage stands in for the attenuator, clocked by the receive clock
            l_d.tx_p = line_in_p;
            l_d.tx_n = line_in_n;
        end else if (all_ones || (pat && gen_bit)) begin
            l_d.tx_p = ~l_q.ami_phase;
            l_d.tx_n = l_q.ami_phase;
            l_d.ami_phase = ~l_q.ami_phase;
        end else if (pat) begin
            l_d.tx_p = 1'b0;
            l_d.tx_n = 1'b0;
        end else begin
            l_d.tx_p = i_tx_positive_data_in;
            l_d.tx_n = i_tx_negative_data_in;
        end
        l_d.loss = pat & ~chk_sync;
        if (chk_err) begin
            l_d.err_toggle = ~l_q.err_toggle;
        end
    end

    // link side state
    always_ff @(posedge i_link_clk) begin
        if (link_rst) begin
            l_q <= '{cfg_meta: `CFG_RESET, cfg_sync: `CFG_RESET, cfg_prev: `CFG_RESET, cfg_used: `CFG_RESET,
                     ins_meta: 1'b0, ins_sync: 1'b0, ins_seen: 1'b0,
                     tx_p: 1'b0, tx_n: 1'b0, ami_phase: 1'b0, rx_p: 1'b0, rx_n: 1'b0, loss: 1'b0,
                     err_toggle: 1'b0};
        end else begin
            l_q <= l_d;
        end
    end

    // falling-edge copy: the toggles differ only for the first half of a clock
    always_ff @(negedge i_link_clk) begin
        if (link_rst) begin
            err_neg <= 1'b0;
        end else begin
            err_neg <= l_q.err_toggle;
        end
    end

    // outputs; the violation output carries sync state while the pattern runs
    assign o_reg_rdata = s_q.rdata;
    assign o_line_tx_positive = l_q.tx_p;
    assign o_line_tx_negative = l_q.tx_n;
    assign o_recovered_clock_out = i_link_clk;
    assign o_rx_positive_data_out = l_q.rx_p;
    assign o_rx_negative_or_violation_out = pat ? (~chk_sync | (l_q.err_toggle ^ err_neg)) : l_q.rx_n;

    // ---------------- checks ----------------
    pattern_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !s_q.pin_sync[3] |=> !s_q.cfg[`CFG_PATTERN]) else $error("pattern mode active in pin mode");

    count_saturate_a: assert property (@(posedge i_clk) disable iff (i_rst)
        s_q.err_cnt == `ERR_CNT_MAX && !cnt_clr |=> s_q.err_cnt == `ERR_CNT_MAX)
        else $error("error counter wrapped");

    read_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rd_low |=> s_q.hold == $past(s_q.err_cnt[15:8]) && s_q.err_cnt <= `ERR_CNT_ONE
            && s_q.rdata == $past(s_q.err_cnt[7:0])) else $error("low byte read did not hold and clear");

    count_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
        err_evt && s_q.cfg[`CFG_PATTERN] && !cnt_clr && s_q.err_cnt != `ERR_CNT_MAX
        |=> s_q.err_cnt == $past(s_q.err_cnt) + `ERR_CNT_ONE) else $error("error not counted");

    insert_edge_a: assert property (@(posedge i_clk) disable iff (i_rst)
        s_d.ins_toggle != s_q.ins_toggle |-> ctrl_wr && !s_q.ctrl[`CTRL_ERR_INSERT])
        else $error("insertion without a 0 to 1 change");

    digital_idle_a: assert property (@(posedge i_link_clk) disable iff (link_rst)
        mode == liu_diag_pkg::loop_digital |=> !o_line_tx_positive && !o_line_tx_negative)
        else $error("line driven during digital loop");

    remote_return_a: assert property (@(posedge i_link_clk) disable iff (link_rst)
        mode == liu_diag_pkg::loop_remote |=> o_line_tx_positive == $past(i_line_rx_positive)
            && o_rx_positive_data_out == $past(i_line_rx_positive)) else $error("remote loop data lost");

    ones_alternate_a: assert property (@(posedge i_link_clk) disable iff (link_rst)
        all_ones && mode == liu_diag_pkg::loop_none ##1 all_ones && mode == liu_diag_pkg::loop_none
        |=> o_line_tx_positive != o_line_tx_negative && o_line_tx_positive == $past(o_line_tx_negative))
        else $error("all-ones marks do not alternate");

    loss_level_a: assert property (@(posedge i_link_clk) disable iff (link_rst)
        pat && !chk_sync |-> o_rx_negative_or_violation_out ##1 (l_q.loss || !$past(pat)))
        else $error("lock loss not shown");
endmodule // liu_diag_top
`default_nettype wire

/* File: verification/line_partner.sv */
// framer and line cable model at the link side of the diagnostics block
`timescale 1ns/100ps
`default_nettype none
module line_partner (
    input wire logic i_link_clk,
    input wire logic i_loop,
    input wire logic i_line_pos,
    input wire logic i_line_neg,
    output logic o_tx_pos,
    output logic o_tx_neg,
    output logic o_rx_pos,
    output logic o_rx_neg
);
    integer seed = 2687; // fixed seed
    logic [31:0] rnd; // raw random word
    logic pol = 1'b0, tp = 1'b0, tn = 1'b0; // ami polarity and rails
    // random marks, each one on the rail opposite the last
    always @(posedge i_link_clk) begin
        rnd = $random(seed);
        tp <= rnd[0] & pol;
        tn <= rnd[0] & ~pol;
        pol <= pol ^ rnd[0];
    end
    assign o_tx_pos = tp;
    assign o_tx_neg = tn;
    // cable looped, or cut: crossed framer rails keep the line busy, never stuck
    assign o_rx_pos = i_loop ? i_line_pos : tn;
    assign o_rx_neg = i_loop ? i_line_neg : tp;
endmodule // line_partner
`default_nettype wire

/* File: verification/liu_prbs_loopback_diagnostics_bench.sv */
// self-checking bench of the line interface diagnostics block
`timescale 1ns/100ps
`default_nettype none
`include "liu_diag_defs.svh"
module liu_prbs_loopback_diagnostics_bench;
    logic clk = 0, lclk = 0, rst = 1, host = 1, rls = 0, lls = 0, aos = 0, wr = 0, rd = 0, rd_d = 0, loop = 1;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata, c;
    logic ltp, ltn, rck, rp, rnv, tp, tn, lrp, lrn;
    logic [1:0] pl = 2'b00, pt = 2'b00; // last line and transmit rails
    logic [8:0] expq[$], e9; // bit 8 marks a read whose value is not checked
    integer error_cnt = 0, tests_run = 0, pulses = 0, lmode = 0;
    always #25 clk = ~clk;
    // link clock offset so its edges drift against the register clock
    initial #7 forever #80 lclk = ~lclk;
    liu_diag_top #(.DEVICE_ID(8'h6c), .SILICON_VER(8'h81)) dut_u (.i_clk(clk), .i_rst(rst), .i_link_clk(lclk),
        .i_host_mode(host), .i_remote_loop_select(rls), .i_local_loop_select(lls), .i_transmit_all_ones(aos),
        .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .i_tx_positive_data_in(tp), .i_tx_negative_data_in(tn), .o_line_tx_positive(ltp), .o_line_tx_negative(ltn),
        .i_line_rx_positive(lrp), .i_line_rx_negative(lrn), .o_recovered_clock_out(rck),
        .o_rx_positive_data_out(rp), .o_rx_negative_or_violation_out(rnv));
    line_partner far_u (.i_link_clk(lclk), .i_loop(loop), .i_line_pos(ltp), .i_line_neg(ltn),
        .o_tx_pos(tp), .o_tx_neg(tn), .o_rx_pos(lrp), .o_rx_neg(lrn));
    task close_out;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one register access; a read notes its expectation for the monitor
    task acc(input logic w, input logic [7:0] a, input logic [8:0] e);
        @(posedge clk);
        addr <= a;
        wd <= e[7:0];
        wr <= w;
        rd <= !w;
        if (!w) expq.push_back(e);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // settle pins first; link checks run only once the config has crossed
    task phase(input integer m);
        lmode = 0;
        repeat (30) @(posedge clk);
        lmode = m;
        repeat (60) @(posedge clk);
    endtask
    // read data stands the cycle after the read edge
    always @(posedge clk) begin
        if (rd_d && expq.size() > 0) begin
            e9 = expq.pop_front();
            if (!e9[8]) chk(rdata, e9[7:0]);
        end
        if (lmode != 0) chk({7'h0, rck}, {7'h0, lclk});
        rd_d <= rd;
    end
    // mid-bit link sampling
    always @(negedge lclk) begin
        if (lmode == 1) chk({6'h0, ltp ^ ltn, ltp ^ pl[1]}, 8'h03);
        if (lmode == 2) chk({4'h0, ltp, ltn, rp, rnv}, {6'h0, pt});
        if (lmode == 3) chk({4'h0, ltp, ltn, rp, rnv}, {4'h0, pt, pl});
        if (lmode == 4) chk({4'h0, ltp, ltn, rp, rnv}, {4'h0, pt[0], pt[1], pt[0], pt[1]});
        pl <= {ltp, ltn};
        pt <= {tp, tn};
    end
    // each rising edge in lock is one detected error
    always @(posedge rnv) pulses++;
    initial begin
        #1_000_000;
        error_cnt++;
        close_out;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        acc(0, `ADDR_CTRL, 9'h000);
        acc(0, `ADDR_DEV_ID, 9'h06c);
        acc(1, `ADDR_DEV_ID, 9'h0ff);
        acc(0, `ADDR_DEV_ID, 9'h06c);
        acc(0, `ADDR_SIL_VER, 9'h081);
        acc(0, 8'h10, 9'h000);
        acc(1, `ADDR_CTRL, 9'h0ff);
        acc(0, `ADDR_CTRL, 9'h03f);
        for (int r = 0; r < 2; r++) begin
            c = r ? 8'h30 : 8'h20; // short then long sequence
            acc(1, `ADDR_CTRL, {1'b0, c});
            repeat (300) @(posedge clk);
            acc(0, `ADDR_STATUS, 9'h000);
            acc(0, `ADDR_ERR_LOW, 9'h100);
            acc(0, `ADDR_ERR_HOLD, 9'h100);
            pulses = 0;
            acc(1, `ADDR_CTRL, {1'b0, c | 8'h08});
            repeat (100) @(posedge clk);
            acc(1, `ADDR_CTRL, {1'b0, c | 8'h08});
            repeat (100) @(posedge clk);
            chk(pulses[7:0], 8'h03);
            acc(0, `ADDR_ERR_HIGH, 9'h000);
            acc(0, `ADDR_ERR_HOLD, 9'h003);
            acc(0, `ADDR_ERR_LOW, 9'h000);
            acc(0, `ADDR_ERR_HOLD, 9'h000);
            acc(1, `ADDR_CTRL, {1'b0, c});
            acc(1, `ADDR_CTRL, {1'b0, c | 8'h08});
            repeat (200) @(posedge clk);
            acc(0, `ADDR_ERR_LOW, 9'h003);
            acc(0, `ADDR_ERR_HOLD, 9'h000);
        end
        loop <= 1'b0;
        repeat (200) @(posedge clk);
        acc(0, `ADDR_STATUS, 9'h001);
        loop <= 1'b1;
        host <= 1'b0;
        phase(3);
        lls <= 1'b1;
        loop <= 1'b0;
        phase(3);
        lls <= 1'b0;
        aos <= 1'b1;
        phase(1);
        aos <= 1'b0;
        rls <= 1'b1;
        phase(4);
        lls <= 1'b1;
        phase(2);
        lmode = 0;
        repeat (5) @(posedge clk);
        close_out;
    end
endmodule // liu_prbs_loopback_diagnostics_bench
`default_nettype wire
